/* logic/sfw_mgr.sv */
// supply fault and warning manager top: registers, alert, aux fault, fault lines
//
// What this block does
// - output overvoltage, undervoltage and overcurrent warnings are compared on telemetry; no undercurrent warning.
// - any warning sets its status bit and pulls the alert line low.
// - a warning never removes a converter enable; only fault responses do.
// - selected overvoltage, overcurrent or undercurrent faults pull the auxiliary fault line low.
// - the auxiliary fault line is released when a channel is commanded back on.
// - each channel's propagate map chooses which shared fault lines its faulted-off state pulls low.
// - each channel's response map shuts it down while any selected shared fault line is low.
// - a channel shut down by a fault line starts again once that line is released.
// - an outside pull of a shared fault line acts only after a 10 us deglitch.
// - holding the watchdog reset line low for the minimum hold time resets the block.
// - power good is the combined good status of the channels mapped to it.
// - the input-voltage share bit enables shared timebase synchronisation of sequencing.
// - the trim code has two full-scale settings, 1.38 V and 2.65 V, and 1023 steps.
// - clear-faults wipes the status register and releases the alert line.
`timescale 1ns/10ps
`include "sfw_params.svh"
module sfw_mgr (
   input  wire logic        CLK,
   input  wire logic        RESET,
   input  wire logic [7:0]  ADDR,
   input  wire logic [15:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [15:0] RDATA,
   input  wire logic        SAMPLE_VALID,
   input  wire logic [1:0]  SAMPLE_CH,
   input  wire logic        SAMPLE_CURR,
   input  wire logic [15:0] SAMPLE_DATA,
   input  wire logic [3:0]  FAULT_OV,
   input  wire logic [3:0]  FAULT_OC,
   input  wire logic [3:0]  FAULT_UC,
   input  wire logic [3:0]  FAULTED_OFF,
   input  wire logic [3:0]  ON_CMD,
   input  wire logic [3:0]  CONV_EN_REQ,
   input  wire logic [3:0]  CH_GOOD,
   input  wire logic [1:0]  FAULT_LINE_I,
   input  wire logic        WDI_RESET_N,
   output logic      [3:0]  CONV_EN,
   output logic      [3:0]  RESTART,
   output logic      [1:0]  FAULT_LINE_O,
   output logic      [1:0]  FAULT_LINE_OE_N,
   output logic             AUX_O,
   output logic             AUX_OE_N,
   output logic             ALERT_O,
   output logic             ALERT_OE_N,
   output logic             IRQ,
   output logic             PGOOD,
   output logic             SEQ_SYNC_EN,
   output logic      [39:0] TRIM_CODE,
   output logic      [3:0]  TRIM_FS_HI,
   output logic      [3:0]  TRIM_POL
);
   localparam logic [7:0] RST_CYC = 8'(`SFW_RST_CYC);

   logic [7:0]              wd_cnt;
   logic                    wd_rst;
   logic [`SFW_STAT_W-1:0]  status;
   logic [`SFW_STAT_W-1:0]  int_en;
   logic [`SFW_CFG_W-1:0]   chcfg  [4];
   logic [`SFW_DAC_W-1:0]   dac    [4];
   logic [15:0]             thr_ov [4];
   logic [15:0]             thr_uv [4];
   logic [15:0]             thr_oc [4];
   logic [1:0]              dgl_low;
   logic [1:0]              dgl_low_q;
   logic [3:0]              shut_q;
   logic [15:0]             rd_val;
   wire  [3:0]              prop_col [2];
   wire  [3:0]              ov_set;
   wire  [3:0]              uv_set;
   wire  [3:0]              oc_set;
   wire  [3:0]              shut;
   wire  [3:0]              aux_ch;
   wire  [3:0]              pg_miss;
   wire  [3:0]              sel;
   wire  [3:0]              v_pol;
   wire  [3:0]              v_fs;
   wire  [1:0]              prop_drv;

   sfw_smp_if smp ();

   // watchdog reset line held low for the hold time resets everything else
   always_ff @(posedge CLK) begin
      if (RESET) begin
         wd_cnt <= 8'h00;
         wd_rst <= 1'b0;
      end else begin
         wd_cnt <= WDI_RESET_N ? 8'h00 : (wd_cnt == RST_CYC ? wd_cnt : wd_cnt + 8'h01);
         wd_rst <= !WDI_RESET_N && (wd_cnt >= RST_CYC - 8'h01);
      end
   end
   wire sys_rst = RESET | wd_rst;

   // bus decode
   wire wr_ctrl   = WR && (ADDR == `SFW_A_CTRL);
   wire wr_clr    = WR && (ADDR == `SFW_A_INT_CLR);
   wire wr_en     = WR && (ADDR == `SFW_A_INT_EN);
   wire wr_cfg    = WR && ((ADDR & `SFW_A_BASE_M) == `SFW_A_CHCFG);
   wire wr_dac    = WR && ((ADDR & `SFW_A_BASE_M) == `SFW_A_DAC);
   wire wr_ovw    = WR && ((ADDR & `SFW_A_BASE_M) == `SFW_A_OVW);
   wire wr_uvw    = WR && ((ADDR & `SFW_A_BASE_M) == `SFW_A_UVW);
   wire wr_ocw    = WR && ((ADDR & `SFW_A_BASE_M) == `SFW_A_OCW);
   wire clear_all = wr_ctrl && WDATA[`SFW_CTRL_CLR];

   // sample carrier to the comparator
   assign smp.valid = SAMPLE_VALID;
   assign smp.ch    = SAMPLE_CH;
   assign smp.kind  = sfw_pkg::sfw_smp_e'(SAMPLE_CURR);
   assign smp.data  = SAMPLE_DATA;

   sfw_warn u_warn (
      .s      (smp),
      .thr_ov (thr_ov),
      .thr_uv (thr_uv),
      .thr_oc (thr_oc),
      .ov_set (ov_set),
      .uv_set (uv_set),
      .oc_set (oc_set)
   );

   // shared fault line filters
   for (genvar l = 0; l < `SFW_NLINE; l++) begin : g_line
      sfw_dgl u_dgl (
         .clk    (CLK),
         .rst    (sys_rst),
         .line_i (FAULT_LINE_I[l]),
         .low    (dgl_low[l])
      );
      assign prop_drv[l] = |(FAULTED_OFF & prop_col[l]);
   end

   // per-channel maps and register storage
   for (genvar c = 0; c < `SFW_NCH; c++) begin : g_ch
      assign sel[c]         = ADDR[1:0] == 2'(c);
      assign prop_col[0][c] = chcfg[c][`SFW_CF_PROP];
      assign prop_col[1][c] = chcfg[c][`SFW_CF_PROP + 1];
      assign shut[c]        = |(chcfg[c][`SFW_CF_RESP +: 2] & dgl_low);
      assign aux_ch[c]      = (FAULT_OV[c] & chcfg[c][`SFW_CF_AUX_OV])
                            | (FAULT_OC[c] & chcfg[c][`SFW_CF_AUX_OC])
                            | (FAULT_UC[c] & chcfg[c][`SFW_CF_AUX_UC]);
      assign pg_miss[c]     = chcfg[c][`SFW_CF_PG] & ~CH_GOOD[c];
      assign v_pol[c]       = chcfg[c][`SFW_CF_DACPOL];
      assign v_fs[c]        = chcfg[c][`SFW_CF_DACFS];
      always_ff @(posedge CLK) begin
         if (sys_rst) begin
            chcfg[c]  <= `SFW_RST_CFG;
            dac[c]    <= `SFW_RST_DAC;
            thr_ov[c] <= `SFW_RST_OVW;
            thr_uv[c] <= `SFW_RST_UVW;
            thr_oc[c] <= `SFW_RST_OCW;
         end else begin
            if (wr_cfg && sel[c]) chcfg[c] <= WDATA[`SFW_CFG_W-1:0];
            if (wr_dac && sel[c]) dac[c] <= WDATA[`SFW_DAC_W-1:0];
            if (wr_ovw && sel[c]) thr_ov[c] <= WDATA;
            if (wr_uvw && sel[c]) thr_uv[c] <= WDATA;
            if (wr_ocw && sel[c]) thr_oc[c] <= WDATA;
         end
      end
   end

   // sticky events: set beats clear, clear-faults wipes all
   wire [1:0] ext_ev  = dgl_low & ~dgl_low_q;
   wire [`SFW_STAT_W-1:0] set_ev = {ext_ev, oc_set, uv_set, ov_set};
   wire [`SFW_STAT_W-1:0] clr_m  = clear_all ? {`SFW_STAT_W{1'b1}}
                                 : (wr_clr ? WDATA[`SFW_STAT_W-1:0] : {`SFW_STAT_W{1'b0}});
   wire [`SFW_STAT_W-1:0] next_status = (status & ~clr_m) | set_ev;
   wire alert_act = |(status & int_en);
   wire next_aux  = |aux_ch | (!AUX_OE_N && !(|ON_CMD));

   // status, alert, aux and open-drain drive
   always_ff @(posedge CLK) begin
      if (sys_rst) begin
         status          <= {`SFW_STAT_W{1'b0}};
         int_en          <= `SFW_RST_INT_EN;
         SEQ_SYNC_EN     <= 1'b0;
         ALERT_OE_N      <= 1'b1;
         IRQ             <= 1'b0;
         AUX_OE_N        <= 1'b1;
         FAULT_LINE_OE_N <= 2'b11;
      end else begin
         status          <= next_status;
         if (wr_en) int_en <= WDATA[`SFW_STAT_W-1:0];
         if (wr_ctrl) SEQ_SYNC_EN <= WDATA[`SFW_CTRL_VSHARE];
         ALERT_OE_N      <= !alert_act;
         IRQ             <= alert_act;
         AUX_OE_N        <= !next_aux;
         FAULT_LINE_OE_N <= ~prop_drv;
      end
   end

   // open-drain data: the pins only ever pull low
   always_ff @(posedge CLK) begin
      FAULT_LINE_O <= 2'b00;
      AUX_O        <= 1'b0;
      ALERT_O      <= 1'b0;
   end

   // converter enables, restart pulses, power good, trim outputs
   always_ff @(posedge CLK) begin
      if (sys_rst) begin
         dgl_low_q  <= 2'b00;
         shut_q     <= 4'h0;
         CONV_EN    <= 4'h0;
         RESTART    <= 4'h0;
         PGOOD      <= 1'b0;
         TRIM_CODE  <= 40'h0;
         TRIM_FS_HI <= 4'h0;
         TRIM_POL   <= 4'h0;
      end else begin
         dgl_low_q  <= dgl_low;
         shut_q     <= shut;
         CONV_EN    <= CONV_EN_REQ & ~shut;
         RESTART    <= shut_q & ~shut;
         PGOOD      <= !(|pg_miss);
         TRIM_CODE  <= {dac[3], dac[2], dac[1], dac[0]};
         TRIM_FS_HI <= v_fs;
         TRIM_POL   <= v_pol;
      end
   end

   // read mux, unmapped reads zero
   always_comb begin
      rd_val = 16'h0000;
      if (ADDR == `SFW_A_CTRL) begin
         rd_val = {14'h0, SEQ_SYNC_EN, 1'b0};
      end else if (ADDR == `SFW_A_STATUS) begin
         rd_val = {2'h0, status};
      end else if (ADDR == `SFW_A_INT_EN) begin
         rd_val = {2'h0, int_en};
      end else if ((ADDR & `SFW_A_BASE_M) == `SFW_A_CHCFG) begin
         rd_val = {6'h0, chcfg[ADDR[1:0]]};
      end else if ((ADDR & `SFW_A_BASE_M) == `SFW_A_DAC) begin
         rd_val = {6'h0, dac[ADDR[1:0]]};
      end else if ((ADDR & `SFW_A_BASE_M) == `SFW_A_OVW) begin
         rd_val = thr_ov[ADDR[1:0]];
      end else if ((ADDR & `SFW_A_BASE_M) == `SFW_A_UVW) begin
         rd_val = thr_uv[ADDR[1:0]];
      end else if ((ADDR & `SFW_A_BASE_M) == `SFW_A_OCW) begin
         rd_val = thr_oc[ADDR[1:0]];
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge CLK) begin
      if (sys_rst) begin
         RDATA <= 16'h0000;
      end else begin
         RDATA <= RD ? rd_val : 16'h0000;
      end
   end

   // checks
   property p_warn_status;
      @(posedge CLK) disable iff (sys_rst)
         (|ov_set) |=> ((status[3:0] & $past(ov_set)) == $past(ov_set));
   endproperty
   a_warn_status: assert property (p_warn_status) else $error("warning bit not set");

   property p_alert_low;
      @(posedge CLK) disable iff (sys_rst) (|(set_ev & int_en) && !wr_en) |=> ##1 !ALERT_OE_N;
   endproperty
   a_alert_low: assert property (p_alert_low) else $error("alert not pulled low");

   property p_clear;
      @(posedge CLK) disable iff (sys_rst)
         (clear_all && !(|set_ev)) |=> (status == 14'h0) ##1 ALERT_OE_N;
   endproperty
   a_clear: assert property (p_clear) else $error("clear faults did not release alert");

   property p_warn_no_off;
      @(posedge CLK) disable iff (sys_rst)
         (CONV_EN_REQ == 4'hf && dgl_low == 2'b00) |=> CONV_EN == 4'hf;
   endproperty
   a_warn_no_off: assert property (p_warn_no_off) else $error("enable dropped without fault");

   property p_aux_set;
      @(posedge CLK) disable iff (sys_rst) (|aux_ch) |=> !AUX_OE_N;
   endproperty
   a_aux_set: assert property (p_aux_set) else $error("aux fault line not pulled");

   property p_aux_rel;
      @(posedge CLK) disable iff (sys_rst) (!AUX_OE_N && (|ON_CMD) && !(|aux_ch)) |=> AUX_OE_N;
   endproperty
   a_aux_rel: assert property (p_aux_rel) else $error("aux fault line not released");

   property p_prop;
      @(posedge CLK) disable iff (sys_rst)
         (FAULTED_OFF[1] && chcfg[1][`SFW_CF_PROP + 1]) |=> !FAULT_LINE_OE_N[1];
   endproperty
   a_prop: assert property (p_prop) else $error("fault line not propagated");

   property p_resp;
      @(posedge CLK) disable iff (sys_rst)
         (dgl_low[0] && chcfg[2][`SFW_CF_RESP]) |=> !CONV_EN[2];
   endproperty
   a_resp: assert property (p_resp) else $error("channel not shut down");

   property p_restart;
      @(posedge CLK) disable iff (sys_rst) (shut_q[2] && !shut[2]) |=> RESTART[2] ##1 !RESTART[2];
   endproperty
   a_restart: assert property (p_restart) else $error("restart pulse wrong");

   property p_pgood;
      @(posedge CLK) disable iff (sys_rst) (CH_GOOD == 4'hf) |=> PGOOD;
   endproperty
   a_pgood: assert property (p_pgood) else $error("power good low with all good");

   property p_wd;
      @(posedge CLK) disable iff (RESET) $rose(wd_rst) |-> !$past(WDI_RESET_N, 2);
   endproperty
   a_wd: assert property (p_wd) else $error("watchdog reset without held line");

   c_aux: cover property (@(posedge CLK) disable iff (sys_rst) $fell(AUX_OE_N));
   c_restart: cover property (@(posedge CLK) disable iff (sys_rst) |RESTART);
   c_clear: cover property (@(posedge CLK) disable iff (sys_rst) clear_all && (|status));
endmodule

/* logic/sfw_params.svh */
// constants of the supply fault and warning manager: offsets, fields, resets, timing
`ifndef SFW_PARAMS_SVH
`define SFW_PARAMS_SVH

// sizes
`define SFW_NCH       4
`define SFW_NLINE     2
`define SFW_STAT_W    14
`define SFW_CFG_W     10
`define SFW_DAC_W     10

// register offsets, word addressed
`define SFW_A_CTRL    8'h00
`define SFW_A_STATUS  8'h01
`define SFW_A_INT_CLR 8'h02
`define SFW_A_INT_EN  8'h03
`define SFW_A_CHCFG   8'h04
`define SFW_A_DAC     8'h08
`define SFW_A_OVW     8'h0c
`define SFW_A_UVW     8'h10
`define SFW_A_OCW     8'h14
`define SFW_A_BASE_M  8'hfc

// control register fields
`define SFW_CTRL_CLR    0
`define SFW_CTRL_VSHARE 1

// channel config fields
`define SFW_CF_PROP   0
`define SFW_CF_RESP   2
`define SFW_CF_AUX_OV 4
`define SFW_CF_AUX_OC 5
`define SFW_CF_AUX_UC 6
`define SFW_CF_DACPOL 7
`define SFW_CF_DACFS  8
`define SFW_CF_PG     9

// status layout
`define SFW_ST_OV     0
`define SFW_ST_UV     4
`define SFW_ST_OC     8
`define SFW_ST_EXT    12

// reset values
`define SFW_RST_INT_EN 14'h3fff
`define SFW_RST_CFG    10'h000
`define SFW_RST_DAC    10'h000
`define SFW_RST_OVW    16'hffff
`define SFW_RST_UVW    16'h0000
`define SFW_RST_OCW    16'hffff

// timing
`define SFW_CLK_NS     50
`define SFW_DGL_NS     10000
`define SFW_RST_HOLD_NS 2000
`define SFW_DGL_CYC    ((`SFW_DGL_NS + `SFW_CLK_NS - 1) / `SFW_CLK_NS)
`define SFW_RST_CYC    ((`SFW_RST_HOLD_NS + `SFW_CLK_NS - 1) / `SFW_CLK_NS)

`endif

/* logic/sfw_pkg.sv */
// types of the supply fault and warning manager
package sfw_pkg;
   typedef enum logic {
      SFW_SMP_VOLT = 1'b0,
      SFW_SMP_CURR = 1'b1
   } sfw_smp_e;
   typedef logic [15:0] sfw_word_t;
endpackage

/* logic/sfw_smp_if.sv */
// telemetry sample carrier between manager and warning comparator
`timescale 1ns/10ps
interface sfw_smp_if;
   logic               valid;
   logic [1:0]         ch;
   sfw_pkg::sfw_smp_e  kind;
   sfw_pkg::sfw_word_t data;
   modport mgr (output valid, output ch, output kind, output data);
   modport cmp (input valid, input ch, input kind, input data);
endinterface

/* logic/sfw_warn.sv */
// warning comparator: telemetry sample against per-channel thresholds
`timescale 1ns/10ps
module sfw_warn (
   sfw_smp_if.cmp             s,
   input  wire logic [15:0]   thr_ov [4],
   input  wire logic [15:0]   thr_uv [4],
   input  wire logic [15:0]   thr_oc [4],
   output wire logic [3:0]    ov_set,
   output wire logic [3:0]    uv_set,
   output wire logic [3:0]    oc_set
);
   wire       is_v = s.valid && (s.kind == sfw_pkg::SFW_SMP_VOLT);
   wire       is_i = s.valid && (s.kind == sfw_pkg::SFW_SMP_CURR);
   wire [3:0] ch_oh = 4'h1 << s.ch;

   // voltage above / below and current above; no current-low warning exists
   assign ov_set = (is_v && s.data > thr_ov[s.ch]) ? ch_oh : 4'h0;
   assign uv_set = (is_v && s.data < thr_uv[s.ch]) ? ch_oh : 4'h0;
   assign oc_set = (is_i && s.data > thr_oc[s.ch]) ? ch_oh : 4'h0;
endmodule

/* logic/sfw_dgl.sv */
// shared fault line synchroniser and low-level deglitch filter
`timescale 1ns/10ps
`include "sfw_params.svh"
module sfw_dgl (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic line_i,
   output logic      low
);
   localparam logic [7:0] DGL = 8'(`SFW_DGL_CYC);
   logic       s1;
   logic       s2;
   logic [7:0] cnt;

   // two-flop synchroniser, then count consecutive low samples
   always_ff @(posedge clk) begin
      if (rst) begin
         s1  <= 1'b1;
         s2  <= 1'b1;
         cnt <= 8'h00;
         low <= 1'b0;
      end else begin
         s1  <= line_i;
         s2  <= s1;
         cnt <= s2 ? 8'h00 : (cnt == DGL ? cnt : cnt + 8'h01);
         low <= !s2 && (cnt >= DGL - 8'h01);
      end
   end

   property p_dgl_glitch;
      @(posedge clk) disable iff (rst) s2 |=> (!low)[*8];
   endproperty
   a_dgl_glitch: assert property (p_dgl_glitch) else $error("fault line low passed before deglitch");

   property p_dgl_done;
      @(posedge clk) disable iff (rst) (!s2 && cnt == DGL - 8'h01) |=> low;
   endproperty
   a_dgl_done: assert property (p_dgl_done) else $error("deglitched low missing");
endmodule

/* verif/sfw_peer_model.sv */
// peer manager model: shares the fault lines, wired-and with pull-ups
`timescale 1ns/10ps
module sfw_peer_model (
   input  wire logic       clk,
   input  wire logic [1:0] pull,
   input  wire logic [1:0] dut_oe_n,
   output logic      [1:0] line
);
   logic [1:0] hold_low = 2'h0;

   // peer pulls a line low on request, launched at a clock edge
   always_ff @(posedge clk) begin
      hold_low <= pull;
   end

   // open-drain resolution: low if any party drives, else pulled up
   assign line = ~(hold_low | ~dut_oe_n);
endmodule

/* verif/test_supply_fault_warning_manager.sv */
// self-checking bench of the supply fault and warning manager
`timescale 1ns/10ps
`include "sfw_params.svh"
module test_supply_fault_warning_manager;
   logic        clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [15:0] wdata = 16'h0000, rdata, sdata = 16'h0000, d;
   logic        sv = 1'b0, scurr = 1'b0, wdi_n = 1'b1;
   logic [1:0]  sch = 2'h0, pull = 2'h0, line, fl_o, fl_oe_n;
   logic [3:0]  f_ov = 4'h0, f_oc = 4'h0, f_uc = 4'h0, foff = 4'h0;
   logic [3:0]  oncmd = 4'h0, enreq = 4'hf, good = 4'h0;
   logic [3:0]  conv_en, restart, fs_hi, pol;
   logic        aux_o, aux_oe_n, al_o, al_oe_n, irq, pgood, sync_en;
   logic [39:0] trim;
   int          n_fail = 0, total_checks = 0, cycles = 0, n;

   sfw_mgr sfw_mgr_inst (.CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
      .RDATA(rdata), .SAMPLE_VALID(sv), .SAMPLE_CH(sch), .SAMPLE_CURR(scurr), .SAMPLE_DATA(sdata),
      .FAULT_OV(f_ov), .FAULT_OC(f_oc), .FAULT_UC(f_uc), .FAULTED_OFF(foff), .ON_CMD(oncmd),
      .CONV_EN_REQ(enreq), .CH_GOOD(good), .FAULT_LINE_I(line), .WDI_RESET_N(wdi_n),
      .CONV_EN(conv_en), .RESTART(restart), .FAULT_LINE_O(fl_o), .FAULT_LINE_OE_N(fl_oe_n),
      .AUX_O(aux_o), .AUX_OE_N(aux_oe_n), .ALERT_O(al_o), .ALERT_OE_N(al_oe_n), .IRQ(irq),
      .PGOOD(pgood), .SEQ_SYNC_EN(sync_en), .TRIM_CODE(trim), .TRIM_FS_HI(fs_hi), .TRIM_POL(pol));

   sfw_peer_model sfw_peer_model_inst (.clk(clk), .pull(pull), .dut_oe_n(fl_oe_n), .line(line));

   // clock, 50 ns period
   initial begin
      forever #25 clk = ~clk;
   end

   // compare and count
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   // one-cycle register write
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask

   // one-cycle read, data taken in the following cycle
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      chk(rdata, e);
   endtask

   // one telemetry sample
   task automatic smp(input logic [1:0] c, input logic cur, input logic [15:0] v);
      @(posedge clk);
      sv <= 1'b1;
      sch <= c;
      scurr <= cur;
      sdata <= v;
      @(posedge clk);
      sv <= 1'b0;
   endtask

   task automatic t_reset;
      rd(`SFW_A_INT_EN, 16'h3fff);
      rd(`SFW_A_OVW, 16'hffff);
      rd(`SFW_A_UVW + 8'h1, 16'h0000);
      rd(8'h20, 16'h0000);
      rd(`SFW_A_STATUS, 16'h0000);
      chk({fl_o, fl_oe_n, aux_oe_n, al_oe_n}, 40'h0f);
      $display("test reset done");
   endtask

   task automatic t_warn;
      wr(`SFW_A_OVW + 8'h1, 16'h1000);
      wr(`SFW_A_UVW + 8'h2, 16'h0100);
      wr(`SFW_A_OCW + 8'h3, 16'h0200);
      smp(2'h1, 1'b0, 16'h1000);
      smp(2'h2, 1'b1, 16'h0050);
      cyc(3);
      chk(al_oe_n, 1'b1);
      smp(2'h1, 1'b0, 16'h1001);
      #1;
      chk(al_oe_n, 1'b1);
      cyc(1);
      chk({al_o, al_oe_n, irq, conv_en}, {2'b00, 1'b1, 4'hf});
      smp(2'h2, 1'b0, 16'h0050);
      smp(2'h3, 1'b1, 16'h0300);
      rd(`SFW_A_STATUS, 16'h0842);
      wr(`SFW_A_STATUS, 16'h0000);
      wr(`SFW_A_INT_EN, 16'h0000);
      cyc(2);
      chk({irq, al_oe_n}, 2'b01);
      wr(`SFW_A_INT_EN, 16'h3fff);
      wr(`SFW_A_INT_CLR, 16'h0002);
      rd(`SFW_A_STATUS, 16'h0840);
      wr(`SFW_A_CTRL, 16'h0001);
      cyc(2);
      rd(`SFW_A_STATUS, 16'h0000);
      chk({al_oe_n, irq}, 2'b10);
      $display("test warn done");
   endtask

   task automatic t_aux;
      for (int k = 0; k < 3; k++) begin
         wr(`SFW_A_CHCFG, 16'h0010 << k);
         @(posedge clk);
         f_ov[0] <= (k == 2);
         f_oc[0] <= (k == 0);
         f_uc[0] <= (k == 1);
         @(posedge clk);
         f_ov <= 4'h0;
         f_oc <= 4'h0;
         f_uc <= 4'h0;
         cyc(2);
         chk(aux_oe_n, 1'b1);
         @(posedge clk);
         f_ov[0] <= (k == 0);
         f_oc[0] <= (k == 1);
         f_uc[0] <= (k == 2);
         @(posedge clk);
         f_ov <= 4'h0;
         f_oc <= 4'h0;
         f_uc <= 4'h0;
         cyc(2);
         chk({aux_o, aux_oe_n}, 2'b00);
         @(posedge clk);
         oncmd <= 4'h1;
         @(posedge clk);
         oncmd <= 4'h0;
         cyc(2);
         chk(aux_oe_n, 1'b1);
      end
      $display("test aux done");
   endtask

   task automatic t_prop;
      for (int l = 0; l < 2; l++) begin
         wr(`SFW_A_CHCFG + 8'h1, 16'h0001 << l);
         foff <= 4'h2;
         cyc(3);
         chk({fl_o, fl_oe_n}, {2'b00, ~(2'b01 << l)});
         @(posedge clk);
         foff <= 4'h0;
         cyc(3);
         chk(fl_oe_n, 2'b11);
      end
      wr(`SFW_A_CHCFG + 8'h1, 16'h0000);
      $display("test propagate done");
   endtask

   task automatic t_resp;
      wr(`SFW_A_CHCFG + 8'h2, 16'h0004);
      pull <= 2'b01;
      cyc(150);
      @(posedge clk);
      pull <= 2'b00;
      cyc(5);
      chk(conv_en, 4'hf);
      @(posedge clk);
      pull <= 2'b01;
      n = 0;
      while (conv_en[2] !== 1'b0 && n < 300) begin
         cyc(1);
         n++;
      end
      chk((n >= 198 && n <= 210), 1'b1);
      chk(conv_en, 4'hb);
      rd(`SFW_A_STATUS, 16'h1000);
      @(posedge clk);
      pull <= 2'b00;
      n = 0;
      while (restart[2] !== 1'b1 && n < 10) begin
         cyc(1);
         n++;
      end
      chk(restart, 4'h4);
      cyc(3);
      chk({restart, conv_en}, 8'h0f);
      wr(`SFW_A_CTRL, 16'h0001);
      $display("test response done");
   endtask

   task automatic t_pg;
      wr(`SFW_A_CHCFG, 16'h0200);
      wr(`SFW_A_CHCFG + 8'h1, 16'h0200);
      good <= 4'h3;
      enreq <= 4'h5;
      cyc(3);
      chk(pgood, 1'b1);
      chk(conv_en, 4'h5);
      @(posedge clk);
      good <= 4'h1;
      enreq <= 4'hf;
      cyc(3);
      chk(pgood, 1'b0);
      @(posedge clk);
      good <= 4'hf;
      cyc(3);
      chk({pgood, conv_en}, 5'h1f);
      $display("test power good done");
   endtask

   task automatic t_trim;
      wr(`SFW_A_DAC + 8'h2, 16'h03ff);
      wr(`SFW_A_DAC + 8'h1, 16'h0001);
      wr(`SFW_A_CHCFG + 8'h3, 16'h0180);
      wr(`SFW_A_CHCFG + 8'h2, 16'h0000);
      wr(`SFW_A_CTRL, 16'h0002);
      cyc(2);
      chk(trim, 40'h00_3ff0_0400);
      chk({fs_hi, pol, sync_en}, 9'h111);
      $display("test trim done");
   endtask

   task automatic t_wdog;
      @(posedge clk);
      wdi_n <= 1'b0;
      cyc(30);
      @(posedge clk);
      wdi_n <= 1'b1;
      cyc(4);
      chk(sync_en, 1'b1);
      @(posedge clk);
      wdi_n <= 1'b0;
      cyc(45);
      @(posedge clk);
      wdi_n <= 1'b1;
      cyc(4);
      chk({sync_en, pol, fs_hi}, 9'h000);
      chk(trim, 40'h0);
      rd(`SFW_A_CHCFG + 8'h3, 16'h0000);
      $display("test watchdog done");
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // hang guard, far above the planned run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         print_verdict();
      end
   end

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_warn();
      t_aux();
      t_prop();
      t_resp();
      t_pg();
      t_trim();
      t_wdog();
      print_verdict();
   end
endmodule
